// ==== common/flash_ctrl_pkg.sv ====
package flash_ctrl_pkg;

    // command codes written on the data pins
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] CMD_IDENTIFIER   = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;

    // identifier locations
    localparam logic [16:0] ID_LOC_MANUFACTURER = 17'h00000;
    localparam logic [16:0] ID_LOC_DEVICE       = 17'h00001;

    // status bit positions
    localparam int READY_BIT_POS        = 7;
    localparam int ERASE_FAIL_BIT_POS   = 5;
    localparam int PROGRAM_FAIL_BIT_POS = 4;
    localparam int SUPPLY_FAULT_BIT_POS = 3;
    localparam logic [7:0] STATUS_AFTER_WAKE = 8'h80;

    // own register map, byte addresses
    localparam logic [5:0] REG_CTRL    = 6'h00;
    localparam logic [5:0] REG_ADDR    = 6'h04;
    localparam logic [5:0] REG_WDATA   = 6'h08;
    localparam logic [5:0] REG_RESULT  = 6'h0C;
    localparam logic [5:0] REG_STATE   = 6'h10;
    localparam logic [5:0] REG_TIMING  = 6'h14;

    // control field: bits 3:1 operation, write with go in bit 0
    localparam logic [2:0] OP_READ          = 3'h0;
    localparam logic [2:0] OP_READ_ARRAY    = 3'h1;
    localparam logic [2:0] OP_READ_ID       = 3'h2;
    localparam logic [2:0] OP_READ_STATUS   = 3'h3;
    localparam logic [2:0] OP_CLEAR_STATUS  = 3'h4;
    localparam logic [2:0] OP_ERASE         = 3'h5;
    localparam logic [2:0] OP_PROGRAM       = 3'h6;
    localparam logic [2:0] OP_POWERDOWN     = 3'h7;

    // pin timing, default strobe and gap widths in cycles, minus one
    localparam logic [7:0] PULSE_CYCLES_RST = 8'h04;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic        ceN;
        logic        oeN;
        logic        weN;
        logic        pwrN;
        logic [16:0] addr;
        logic [7:0]  dOut;
        logic        dOe;
    } flash_pins_t;

    typedef struct packed {
        logic       go;
        logic [2:0] op;
        logic [16:0] addr;
        logic [7:0] data;
    } flash_req_t;

endpackage

// ==== rtl/flash_pin_sync.sv ====
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs
module flash_pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
        end
        else if (clkEn)
        begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;
endmodule

// ==== rtl/flash_command_interface.sv ====
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - pin-strapped id read: locations zero and one
// - only another valid command leaves id mode; the model also leaves it on power-down
// - write strobe low with select; rising edge captures
// - program: 40H then byte, same location
// - raise enable between status reads
// - clear status after supply fault before writes
// - erase: 20H then D0H, block address
// - never erase at intermediate supply; supply is not sensed here, software gates erase
// - after erase check fail bit, then clear
module flash_command_interface (
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire logic                       clkEn,
    // AXI4-Lite slave
    input  wire logic [5:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [5:0]                 s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // flash pins
    output flash_ctrl_pkg::flash_pins_t     flashPins,
    input  wire logic [7:0]                 flashDataIn
);
    typedef enum logic [6:0] {
        ST_IDLE   = 7'b0000001,
        ST_SETUP  = 7'b0000010,
        ST_STROBE = 7'b0000100,
        ST_HOLD   = 7'b0001000,
        ST_READ   = 7'b0010000,
        ST_GAP    = 7'b0100000,
        ST_WAKE   = 7'b1000000
    } seq_state_t;

    seq_state_t  state_r, state_nxt;
    flash_ctrl_pkg::flash_req_t req_r;
    flash_ctrl_pkg::flash_pins_t pins_r;
    logic [7:0]  pulse_r;
    logic [7:0]  cnt_r;
    logic        second_r;
    logic        busy;
    logic [7:0]  result_r;
    logic [7:0]  lastCmd_r;
    logic [7:0]  dataSync;
    logic        cntDone;
    logic        twoCycle;
    logic [7:0]  firstByte;
    logic [7:0]  secondByte;
    logic        isWrite;
    logic        useSecond;

    // bus side
    logic        awHeld_r, wHeld_r;
    logic [5:0]  awAddr_r;
    logic [31:0] wData_r;
    logic        bvalid_r, rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  bresp_r, rresp_r;
    logic        wrFire;
    logic        arFire;
    logic        ctrlHit;
    logic        wrMapped;
    logic        rdMapped;
    logic [31:0] rdMux;

    flash_pin_sync #(.WIDTH(8)) u_dq_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .clkEn   (clkEn),
        .asyncIn (flashDataIn),
        .syncOut (dataSync)
    );

    function automatic logic mapped(input logic [5:0] a);
        mapped = (a == flash_ctrl_pkg::REG_CTRL) || (a == flash_ctrl_pkg::REG_ADDR)
              || (a == flash_ctrl_pkg::REG_WDATA) || (a == flash_ctrl_pkg::REG_RESULT)
              || (a == flash_ctrl_pkg::REG_STATE) || (a == flash_ctrl_pkg::REG_TIMING);
    endfunction

    assign busy      = (state_r != ST_IDLE);
    assign wrFire    = awHeld_r && wHeld_r && !bvalid_r;
    assign arFire    = s_axi_arvalid && s_axi_arready;
    assign ctrlHit   = wrFire && (awAddr_r == flash_ctrl_pkg::REG_CTRL) && wData_r[0];
    assign wrMapped  = mapped(awAddr_r) && (awAddr_r != flash_ctrl_pkg::REG_RESULT)
                     && (awAddr_r != flash_ctrl_pkg::REG_STATE);
    assign rdMapped  = mapped(s_axi_araddr);
    assign s_axi_awready = !awHeld_r && !bvalid_r;
    assign s_axi_wready  = !wHeld_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign rdMux =
        (s_axi_araddr == flash_ctrl_pkg::REG_CTRL)   ? {28'h0000000, req_r.op, busy} :
        (s_axi_araddr == flash_ctrl_pkg::REG_ADDR)   ? {15'h0000, req_r.addr} :
        (s_axi_araddr == flash_ctrl_pkg::REG_WDATA)  ? {24'h000000, req_r.data} :
        (s_axi_araddr == flash_ctrl_pkg::REG_RESULT) ? {24'h000000, result_r} :
        (s_axi_araddr == flash_ctrl_pkg::REG_STATE)  ? {17'h00000, state_r, lastCmd_r} :
        (s_axi_araddr == flash_ctrl_pkg::REG_TIMING) ? {24'h000000, pulse_r} :
                                                        32'h00000000;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awAddr_r <= 6'h00;
            wData_r  <= 32'h00000000;
            bvalid_r <= 1'b0;
            bresp_r  <= flash_ctrl_pkg::AXI_OKAY;
        end
        else if (clkEn)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
            end
            if (wrFire)
            begin
                awHeld_r <= 1'b0;
                wHeld_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= (wrMapped && !(ctrlHit && busy)) ? flash_ctrl_pkg::AXI_OKAY
                                                             : flash_ctrl_pkg::AXI_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= flash_ctrl_pkg::AXI_OKAY;
        end
        else if (clkEn)
        begin
            if (arFire)
            begin
                rvalid_r <= 1'b1;
                rdata_r  <= rdMux;
                rresp_r  <= rdMapped ? flash_ctrl_pkg::AXI_OKAY : flash_ctrl_pkg::AXI_SLVERR;
            end
            else if (rvalid_r && s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end

    // command byte per operation; program and erase need two write cycles
    always_comb
    begin
        firstByte  = flash_ctrl_pkg::CMD_READ_ARRAY;
        secondByte = req_r.data;
        twoCycle   = 1'b0;
        isWrite    = 1'b1;
        case (req_r.op)
            flash_ctrl_pkg::OP_READ:         isWrite = 1'b0;
            flash_ctrl_pkg::OP_READ_ARRAY:   firstByte = flash_ctrl_pkg::CMD_READ_ARRAY;
            flash_ctrl_pkg::OP_READ_ID:      firstByte = flash_ctrl_pkg::CMD_IDENTIFIER;
            flash_ctrl_pkg::OP_READ_STATUS:  firstByte = flash_ctrl_pkg::CMD_READ_STATUS;
            flash_ctrl_pkg::OP_CLEAR_STATUS: firstByte = flash_ctrl_pkg::CMD_CLEAR_STATUS;
            flash_ctrl_pkg::OP_ERASE:
            begin
                // supply level is not sensed here, software gates erase
                firstByte  = flash_ctrl_pkg::CMD_ERASE_SETUP;
                secondByte = flash_ctrl_pkg::CMD_ERASE_CONFIRM;
                twoCycle   = 1'b1;
            end
            flash_ctrl_pkg::OP_PROGRAM:
            begin
                firstByte = flash_ctrl_pkg::CMD_PROGRAM_SETUP;
                twoCycle  = 1'b1;
            end
            default:                         isWrite = 1'b0;
        endcase
    end

    assign cntDone = (cnt_r == 8'h00);
    // second write cycle keeps its own byte through the whole setup phase
    assign useSecond = (state_r == ST_HOLD) || (state_r == ST_SETUP && second_r);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (ctrlHit)
                    state_nxt = (wData_r[3:1] == flash_ctrl_pkg::OP_POWERDOWN) ? ST_WAKE
                              : ST_SETUP;
            ST_SETUP:  if (cntDone) state_nxt = isWrite ? ST_STROBE : ST_READ;
            ST_STROBE: if (cntDone) state_nxt = ST_HOLD;
            ST_HOLD:   if (cntDone) state_nxt = (twoCycle && !second_r) ? ST_SETUP : ST_GAP;
            ST_READ:   if (cntDone) state_nxt = ST_GAP;
            ST_GAP:    if (cntDone) state_nxt = ST_IDLE;
            ST_WAKE:   if (cntDone) state_nxt = ST_GAP;
            default:   state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r   <= ST_IDLE;
            cnt_r     <= 8'h00;
            second_r  <= 1'b0;
            pulse_r   <= flash_ctrl_pkg::PULSE_CYCLES_RST;
            req_r     <= '0;
            result_r  <= 8'h00;
            lastCmd_r <= flash_ctrl_pkg::CMD_READ_ARRAY;
        end
        else if (clkEn)
        begin
            state_r <= state_nxt;
            cnt_r   <= (state_nxt != state_r || (state_r == ST_HOLD && cntDone))
                       ? pulse_r : cnt_r - 8'h01;
            if (!busy && wrFire && awAddr_r == flash_ctrl_pkg::REG_ADDR)
                req_r.addr <= wData_r[16:0];
            if (!busy && wrFire && awAddr_r == flash_ctrl_pkg::REG_WDATA)
                req_r.data <= wData_r[7:0];
            if (!busy && wrFire && awAddr_r == flash_ctrl_pkg::REG_TIMING)
                pulse_r <= (wData_r[7:0] == 8'h00) ? 8'h01 : wData_r[7:0];
            if (state_r == ST_IDLE && ctrlHit)
            begin
                req_r.op <= wData_r[3:1];
                second_r <= 1'b0;
            end
            if (state_r == ST_HOLD && cntDone)
            begin
                second_r  <= 1'b1;
                lastCmd_r <= second_r ? secondByte : firstByte;
            end
            // sample at end of read, with enable still low
            if (state_r == ST_READ && cntDone)
                result_r <= dataSync;
        end
    end

    // pin drive: address and data held steady across the strobe
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pins_r <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, pwrN: 1'b1,
                        addr: 17'h00000, dOut: 8'h00, dOe: 1'b0};
        end
        else if (clkEn)
        begin
            pins_r.pwrN <= (state_nxt != ST_WAKE);
            pins_r.ceN  <= !(state_nxt == ST_SETUP || state_nxt == ST_STROBE
                          || state_nxt == ST_HOLD || state_nxt == ST_READ);
            // separate strobe per write cycle, second cycle same address
            pins_r.weN  <= !(state_nxt == ST_STROBE);
            // enable raised between reads so status latch refreshes
            pins_r.oeN  <= !(state_nxt == ST_READ);
            pins_r.dOe  <= isWrite && (state_nxt == ST_SETUP || state_nxt == ST_STROBE
                          || state_nxt == ST_HOLD);
            pins_r.addr <= req_r.addr;
            if (state_nxt == ST_SETUP)
                pins_r.dOut <= useSecond ? secondByte : firstByte;
        end
    end

    assign flashPins = pins_r;
endmodule

// ==== tb/flash_command_interface_checker.sv ====
`timescale 1ns/1ps
module flash_command_interface_checker (
    input wire logic                        clk,
    input wire logic                        arst_n,
    input wire flash_ctrl_pkg::flash_pins_t flashPins,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    strobe_needs_ce_a: assert property (!flashPins.weN |-> !flashPins.ceN)
        else $error("write strobe without select");
    no_read_write_a: assert property (!(!flashPins.weN && !flashPins.oeN))
        else $error("read and write enables together");
    write_data_driven_a: assert property (!flashPins.weN |-> flashPins.dOe)
        else $error("strobe without driven data");
    strobe_hold_a: assert property (!flashPins.weN && $past(!flashPins.weN)
        |-> $stable(flashPins.addr) && $stable(flashPins.dOut)) else $error("moved under strobe");
    pair_addr_a: assert property (!flashPins.ceN && $past(!flashPins.ceN)
        |-> $stable(flashPins.addr)) else $error("address moved while selected");
    read_no_drive_a: assert property (!flashPins.oeN |-> !flashPins.dOe)
        else $error("bus contention on read");
    status_relatch_a: assert property ($rose(flashPins.oeN) |=> flashPins.oeN)
        else $error("read enable not released");
    powerdown_quiet_a: assert property (!flashPins.pwrN
        |-> flashPins.ceN && flashPins.oeN && flashPins.weN) else $error("strobe in power-down");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    cover property ($rose(flashPins.weN));
    cover property ($fell(flashPins.oeN));
    cover property ($fell(flashPins.pwrN));
endmodule
bind flash_command_interface flash_command_interface_checker CHK (.clk(clk), .arst_n(arst_n),
    .flashPins(flashPins), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// ==== tb/flash_device_model.sv ====
`timescale 1ns/1ps
module flash_device_model #(
    parameter logic [7:0] MFR_CODE = 8'hA5, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h5A, // arbitrary value
    parameter int         BUSY_NS  = 8000
) (
    input  wire flash_ctrl_pkg::flash_pins_t pins,
    input  wire logic                        vppHigh,
    input  wire logic                        failErase,
    output logic [7:0]                       dq
);
    logic [7:0] mem [0:255];
    logic [7:0] sts = 8'h80;
    logic [7:0] srLatch = 8'h80;
    logic [7:0] setup = 8'hFF;
    logic [7:0] lastVal = 8'h00;
    logic [1:0] mode = 2'h0;
    wire        rdEn = !pins.ceN && !pins.oeN && pins.pwrN;
    wire  [7:0] idVal = (pins.addr == flash_ctrl_pkg::ID_LOC_DEVICE) ? DEV_CODE : MFR_CODE;
    wire  [7:0] rdVal = mode == 2'h0 ? mem[pins.addr[7:0]] : mode == 2'h1 ? idVal : srLatch;
    // released lines show the inverse of the last byte
    assign dq = rdEn ? rdVal : ~lastVal;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0] ^ 8'h3C;
    end
    always @(negedge rdEn) lastVal = rdVal;
    always @(negedge pins.oeN or negedge pins.ceN)
        if (!pins.oeN && !pins.ceN) srLatch = sts;
    always @(posedge pins.pwrN)
    begin
        mode = 2'h0;
        sts = 8'h80;
        setup = 8'hFF;
    end
    task automatic runOp(input int pos, input logic fail);
        fork
        begin
            sts[7] = 1'b0;
            #(BUSY_NS);
            sts[7] = 1'b1;
            if (fail) sts[pos] = 1'b1;
        end
        join_none
    endtask
    always @(posedge pins.weN)
    begin
        if (!pins.ceN && pins.pwrN)
        begin
            if (setup != 8'hFF)
            begin
                mode = 2'h2;
                if (!vppHigh) sts[3] = 1'b1;
                else if (setup == flash_ctrl_pkg::CMD_PROGRAM_SETUP)
                begin
                    mem[pins.addr[7:0]] = pins.dOut;
                    runOp(4, 1'b0);
                end
                else if (pins.dOut == flash_ctrl_pkg::CMD_ERASE_CONFIRM) runOp(5, failErase);
                setup = 8'hFF;
            end
            else case (pins.dOut)
                flash_ctrl_pkg::CMD_READ_ARRAY:   if (sts[7]) mode = 2'h0;
                flash_ctrl_pkg::CMD_IDENTIFIER:   mode = 2'h1;
                flash_ctrl_pkg::CMD_READ_STATUS:  mode = 2'h2;
                flash_ctrl_pkg::CMD_CLEAR_STATUS: sts[5:3] = 3'h0;
                flash_ctrl_pkg::CMD_ERASE_SETUP,
                flash_ctrl_pkg::CMD_PROGRAM_SETUP: setup = pins.dOut;
                default: ;
            endcase
        end
    end
endmodule

// ==== tb/flash_command_interface_tb.sv ====
`timescale 1ns/1ps
module flash_command_interface_tb;
    typedef struct {
        logic [1:0]  cfg;
        logic [2:0]  op;
        logic [16:0] addr;
        logic [7:0]  data;
        int          waitc;
        logic [8:0]  exp;
    } row_t;
    logic clk, arst_n, awValid, wValid, bReady, arValid, rReady, vppHigh, failErase, clkEn;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [5:0] awAddr, arAddr;
    logic [31:0] wData, rData, res;
    logic [1:0] bResp, rResp, r;
    logic [7:0] dataIn;
    flash_ctrl_pkg::flash_pins_t pins;
    flash_ctrl_pkg::flash_pins_t held;
    int err_total = 0;
    int num_checks = 0;
    row_t rows [15] = '{
        '{2'h0, 3'h1, 17'h00012, 8'h00, 0, 9'h12E},
        '{2'h0, 3'h2, 17'h00001, 8'h00, 0, 9'h15A},
        '{2'h0, 3'h0, 17'h00000, 8'h00, 0, 9'h1A5},
        '{2'h0, 3'h3, 17'h00000, 8'h00, 0, 9'h180},
        '{2'h0, 3'h5, 17'h00100, 8'h00, 0, 9'h188},
        '{2'h0, 3'h4, 17'h00000, 8'h00, 0, 9'h180},
        '{2'h0, 3'h1, 17'h00005, 8'h00, 0, 9'h139},
        '{2'h3, 3'h5, 17'h00100, 8'h00, 0, 9'h100},
        '{2'h3, 3'h1, 17'h00000, 8'h00, 0, 9'h100},
        '{2'h3, 3'h0, 17'h00000, 8'h00, 400, 9'h1A0},
        '{2'h2, 3'h6, 17'h00007, 8'h55, 400, 9'h1A0},
        '{2'h2, 3'h4, 17'h00007, 8'h00, 0, 9'h180},
        '{2'h2, 3'h1, 17'h00007, 8'h00, 0, 9'h155},
        '{2'h2, 3'h2, 17'h00000, 8'h00, 0, 9'h1A5},
        '{2'h2, 3'h7, 17'h00003, 8'h00, 0, 9'h13F}};
    flash_command_interface DUT (.clk(clk), .arst_n(arst_n), .clkEn(clkEn),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .flashPins(pins), .flashDataIn(dataIn));
    flash_device_model MODEL (.pins(pins), .vppHigh(vppHigh), .failErase(failErase), .dq(dataIn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axiWr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(aw && w))
        begin
            @(negedge clk);
            aw = aw || awReady;
            w = w || wReady;
            @(posedge clk);
            awValid <= !aw;
            wValid <= !w;
        end
        do @(negedge clk); while (!bValid);
        rs = bResp;
        @(posedge clk);
        bReady <= 1'b0;
    endtask
    task automatic axiRd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(negedge clk); while (!arReady);
        @(posedge clk);
        arValid <= 1'b0;
        do @(negedge clk); while (!rValid);
        d = rData;
        rs = rResp;
        @(posedge clk);
        rReady <= 1'b0;
    endtask
    task automatic waitIdle;
        res = 32'h1;
        while (res[0] !== 1'b0) axiRd(flash_ctrl_pkg::REG_CTRL, res, r);
    endtask
    task automatic doOp(input logic [2:0] op, input logic [16:0] a, input logic [7:0] d);
        axiWr(flash_ctrl_pkg::REG_ADDR, {15'h0000, a}, r);
        axiWr(flash_ctrl_pkg::REG_WDATA, {24'h000000, d}, r);
        axiWr(flash_ctrl_pkg::REG_CTRL, {28'h0000000, op, 1'b1}, r);
        chk({30'h0, r}, {30'h0, flash_ctrl_pkg::AXI_OKAY});
        waitIdle();
        axiRd(flash_ctrl_pkg::REG_RESULT, res, r);
    endtask
    task automatic rst;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (10) @(posedge clk);
        chk({27'h0, pins.ceN, pins.oeN, pins.weN, pins.pwrN, pins.dOe}, 32'h1E);
        arst_n <= 1'b1;
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        #500us;
        err_total++;
        complete_run();
    end
    initial
    begin
        {arst_n, awValid, wValid, bReady, arValid, rReady, vppHigh, failErase} = 8'h00;
        {awAddr, arAddr, wData} = 44'h0;
        clkEn = 1'b1;
        rst();
        foreach (rows[i])
        begin
            vppHigh <= rows[i].cfg[1];
            failErase <= rows[i].cfg[0];
            doOp(rows[i].op, rows[i].addr, rows[i].data);
            repeat (rows[i].waitc) @(posedge clk);
            doOp(flash_ctrl_pkg::OP_READ, rows[i].addr, 8'h00);
            chk(res, {24'h0, rows[i].exp[7:0]});
        end
        vppHigh <= 1'b0;
        doOp(flash_ctrl_pkg::OP_PROGRAM, 17'h00009, 8'h77);
        axiRd(flash_ctrl_pkg::REG_STATE, res, r);
        chk(res, 32'h00000177);
        doOp(flash_ctrl_pkg::OP_READ, 17'h00009, 8'h00);
        chk(res, 32'h00000088);
        doOp(flash_ctrl_pkg::OP_CLEAR_STATUS, 17'h00000, 8'h00);
        axiRd(flash_ctrl_pkg::REG_TIMING, res, r);
        chk(res, {24'h0, flash_ctrl_pkg::PULSE_CYCLES_RST});
        axiRd(6'h3C, res, r);
        chk({30'h0, r}, {30'h0, flash_ctrl_pkg::AXI_SLVERR});
        axiWr(6'h20, 32'h0, r);
        chk({30'h0, r}, {30'h0, flash_ctrl_pkg::AXI_SLVERR});
        axiWr(flash_ctrl_pkg::REG_RESULT, 32'h0, r);
        chk({30'h0, r}, {30'h0, flash_ctrl_pkg::AXI_SLVERR});
        axiWr(flash_ctrl_pkg::REG_CTRL, {28'h0, flash_ctrl_pkg::OP_READ_STATUS, 1'b1}, r);
        axiWr(flash_ctrl_pkg::REG_CTRL, {28'h0, flash_ctrl_pkg::OP_READ_ARRAY, 1'b1}, r);
        chk({30'h0, r}, {30'h0, flash_ctrl_pkg::AXI_SLVERR});
        // freeze the sequencer mid-operation: pins must not move
        @(posedge clk);
        clkEn <= 1'b0;
        @(posedge clk);
        held = pins;
        repeat (20) @(posedge clk);
        chk({2'h0, pins}, {2'h0, held});
        clkEn <= 1'b1;
        waitIdle();
        doOp(flash_ctrl_pkg::OP_READ, 17'h00000, 8'h00);
        chk(res, 32'h80);
        rst();
        doOp(flash_ctrl_pkg::OP_READ, 17'h00000, 8'h00);
        chk(res, 32'h80);
        complete_run();
    end
endmodule
